// ---- hw/htd_top.sv ----
`default_nettype none

// Function
// [RL1] Hardware traps vector at once, unmaskable
// [RL2] Each hardware trap sets its flag
// [RL3] Trap preempts unless higher trap running
// [RL4] Trap service blocks node interrupts
// [RL5] All resets restart at vector zero
// [RL6] Class A traps own vectors and flags
// [RL7] Class B traps share one vector
// [RL8] Software trap any number, current priority
// [RL9] Nodes have request, enable, fixed vector
// [RL10] Bidir enable frozen after init, reset-cleared
// [RL11] Bidir mode reports long hardware reset
// [RL12] Bidir mode latches startup config
// [RL13] Bidir mode stretches short reset
// [RL14] External reset drives pin open-drain only
// [RL15] Vector address is four times number
// [RL16] Trap flags cleared only by software
module htd_top (
    input  wire logic                 sys_clk,              // CPU clock
    input  wire logic                 reset_n,              // Async reset
    input  wire logic [7:0]           avs_address,          // Byte address
    input  wire logic                 avs_read,             // Read strobe
    input  wire logic                 avs_write,            // Write strobe
    input  wire logic [31:0]          avs_writedata,        // Write data
    output logic      [31:0]          avs_readdata,         // Read data
    output logic                      avs_waitrequest,      // Stall
    input  wire logic [7:0]           hw_trap_evt,          // Trap pulses
    input  wire logic                 sw_trap_req,          // Trap instr
    input  wire logic [6:0]           sw_trap_num,          // Its number
    input  wire logic                 trap_return,          // Service end
    input  wire logic [3:0]           node_evt,             // Node sources
    input  wire logic                 vec_take,             // Vector taken
    output htd_pkg::htd_vec_t         vec_out,              // Vector fetch
    output logic                      block_irq,            // Nodes held
    input  wire logic                 sw_reset_req,         // Soft reset
    input  wire logic                 wdt_overflow,         // Watchdog
    input  wire logic                 end_of_init_instruction, // Init done
    input  wire logic                 reset_input_pin_in,   // Pin level
    output logic                      reset_input_pin_out,  // Pin drive
    output logic                      reset_input_pin_oe,   // Pulls low
    input  wire logic [15:0]          startup_config_port,  // Straps
    output logic                      core_reset,           // Core held
    output logic                      bootstrap_mode,       // Loader on
    output logic                      irq                   // Interrupt
);
    htd_pkg::htd_state_t  s_reg;
    htd_pkg::htd_state_t  s_next;
    logic [3:0]           node_req;
    logic [3:0]           node_en;
    logic [3:0]           node_take;
    logic                 acc;
    logic                 wr;
    logic                 rst_start;
    logic                 pin_low;

    // Bus access is taken only while the stall is up
    assign acc       = s_reg.wait_rq && (avs_read || avs_write);
    assign wr        = acc && avs_write;
    assign pin_low   = !reset_input_pin_in;
    assign rst_start = !s_reg.seq_busy &&
                       (pin_low || sw_reset_req || wdt_overflow);

    // Interrupt nodes, one per source
    for (genvar g = 0; g < htd_pkg::NODE_COUNT; g++)
    begin : g_node
        htd_node u_node (
            .sys_clk (sys_clk),
            .reset_n (reset_n),
            .set_evt (node_evt[g]),
            .take    (node_take[g]),
            .wr_req  (wr && avs_address == htd_pkg::OFF_NODE_REQ),
            .wr_en   (wr && avs_address == htd_pkg::OFF_NODE_EN),
            .req_d   (avs_writedata[g]),
            .en_d    (avs_writedata[g]),
            .req     (node_req[g]),
            .en      (node_en[g])
        );
    end

    // Next state: bus, dispatch, reset sequence, status
    always_comb
    begin
        logic             a_hit;
        logic [6:0]       a_num;
        logic [2:0]       a_bit;
        logic             n_hit;
        logic [1:0]       n_idx;
        a_hit     = 1'b0;
        a_num     = '0;
        a_bit     = '0;
        n_hit     = 1'b0;
        n_idx     = '0;
        node_take = '0;
        s_next    = s_reg;
        s_next.wait_rq = !acc;
        if (acc && avs_read)
        begin
            unique case (avs_address)
                htd_pkg::OFF_TRAP_FLAG: s_next.rdata = 32'(s_reg.tflag);
                htd_pkg::OFF_SYS_CFG:
                    s_next.rdata = {30'h0, s_reg.end_of_init_instruction_done, s_reg.bidir_en};
                htd_pkg::OFF_RST_IND:  s_next.rdata = 32'(s_reg.rst_ind);
                htd_pkg::OFF_BOOT_CFG: s_next.rdata = 32'(s_reg.boot_cfg);
                htd_pkg::OFF_NODE_REQ: s_next.rdata = 32'(node_req);
                htd_pkg::OFF_NODE_EN:  s_next.rdata = 32'(node_en);
                htd_pkg::OFF_IRQ_STAT: s_next.rdata = 32'(s_reg.ist);
                htd_pkg::OFF_IRQ_MASK: s_next.rdata = 32'(s_reg.imask);
                default:               s_next.rdata = 32'h0000_0000;
            endcase
        end
        // Register writes; ones clear sticky bits
        if (wr)
        begin
            if (avs_address == htd_pkg::OFF_TRAP_FLAG)
                s_next.tflag = s_reg.tflag & ~avs_writedata[7:0]; // RL16
            if (avs_address == htd_pkg::OFF_SYS_CFG && !s_reg.end_of_init_instruction_done)
                s_next.bidir_en = avs_writedata[htd_pkg::SC_BIDIR]; // RL10
            if (avs_address == htd_pkg::OFF_IRQ_STAT)
                s_next.ist = s_reg.ist & ~avs_writedata[3:0];
            if (avs_address == htd_pkg::OFF_IRQ_MASK)
                s_next.imask = avs_writedata[3:0];
        end
        if (end_of_init_instruction)
            s_next.end_of_init_instruction_done = 1'b1;
        if (trap_return)
        begin
            s_next.lvl      = s_reg.prev_lvl;
            s_next.prev_lvl = htd_pkg::LVL_NONE;
        end
        // Lowest index wins among class A and among nodes
        for (int k = htd_pkg::A_COUNT - 1; k >= 0; k--)
        begin
            if (s_reg.pend[k])
            begin
                a_hit = 1'b1;
                a_num = htd_pkg::A_NUM[k];
                a_bit = 3'(k);
            end
        end
        for (int k = htd_pkg::NODE_COUNT - 1; k >= 0; k--)
        begin
            if (node_req[k] && node_en[k])
            begin
                n_hit = 1'b1;
                n_idx = 2'(k);
            end
        end
        // One vector outstanding at a time; pipeline must take it
        if (s_reg.vec.valid)
        begin
            if (vec_take)
                s_next.vec.valid = 1'b0;
        end
        else if (!s_reg.seq_busy && !rst_start) // No node request lost
        begin
            if (a_hit && s_reg.lvl != htd_pkg::LVL_A)               // RL3
            begin
                s_next.vec        = htd_pkg::vec_of(a_num);          // RL6
                s_next.pend[a_bit] = 1'b0;
                s_next.prev_lvl   = s_reg.lvl;
                s_next.lvl        = htd_pkg::LVL_A;                  // RL1
                s_next.ist[htd_pkg::IS_CLASS_A] = 1'b1;
            end
            else if (|s_reg.pend[htd_pkg::HW_COUNT-1:htd_pkg::A_COUNT] &&
                     s_reg.lvl == htd_pkg::LVL_NONE)
            begin
                s_next.vec = htd_pkg::vec_of(htd_pkg::NUM_CLASS_B);  // RL7
                s_next.pend[htd_pkg::HW_COUNT-1:htd_pkg::A_COUNT] = '0;
                s_next.prev_lvl = s_reg.lvl;
                s_next.lvl      = htd_pkg::LVL_B;
                s_next.ist[htd_pkg::IS_CLASS_B] = 1'b1;
            end
            else if (s_reg.sw_pend)
            begin
                // Runs at the current level, so level is left alone
                s_next.vec     = htd_pkg::vec_of(s_reg.sw_num);      // RL8
                s_next.sw_pend = 1'b0;
                s_next.ist[htd_pkg::IS_SW] = 1'b1;
            end
            else if (n_hit && s_reg.lvl == htd_pkg::LVL_NONE)        // RL4
            begin
                s_next.vec       = htd_pkg::vec_of(htd_pkg::NODE_NUM[n_idx]);
                node_take[n_idx] = 1'b1;                             // RL9
            end
        end
        if (sw_trap_req && !s_reg.sw_pend)
        begin
            s_next.sw_pend = 1'b1;
            s_next.sw_num  = sw_trap_num;
        end
        // Event sets come after the write and dispatch clears; a reset start still clears pend
        s_next.tflag = s_next.tflag | hw_trap_evt;                  // RL2
        s_next.pend  = s_next.pend | hw_trap_evt;                   // RL1
        // Internal reset sequence
        if (rst_start)
        begin
            s_next.seq_busy   = 1'b1;
            s_next.core_rst   = 1'b1;
            s_next.seq_cnt    = htd_pkg::CNT_W'(htd_pkg::RST_SEQ_CYC - 1);
            s_next.low_cnt    = '0;
            s_next.seq_bidir  = s_reg.bidir_en;
            s_next.bidir_en   = 1'b0;                               // RL10
            s_next.end_of_init_instruction_done = 1'b0;
            s_next.pin_oe     = s_reg.bidir_en;                     // RL13
            s_next.pend       = '0;
            s_next.sw_pend    = 1'b0;
            s_next.lvl        = htd_pkg::LVL_NONE;
            s_next.prev_lvl   = htd_pkg::LVL_NONE;
            s_next.vec.valid  = 1'b0;
            if (pin_low)
                s_next.src = htd_pkg::SRC_HW;
            else if (wdt_overflow)
                s_next.src = htd_pkg::SRC_WDT;
            else
                s_next.src = htd_pkg::SRC_SW;
        end
        else if (s_reg.seq_busy)
        begin
            if (pin_low &&
                s_reg.low_cnt != htd_pkg::CNT_W'(htd_pkg::LONG_RST_CYC))
                s_next.low_cnt = s_reg.low_cnt + 1'b1;
            if (s_reg.seq_cnt != '0)
                s_next.seq_cnt = s_reg.seq_cnt - 1'b1;
            else if (!(pin_low && !s_reg.seq_bidir))
            begin
                // Own pin drive is ignored once the stretch ends
                s_next.seq_busy = 1'b0;
                s_next.core_rst = 1'b0;
                s_next.pin_oe   = 1'b0;
                s_next.vec      = htd_pkg::vec_of(htd_pkg::NUM_RESET); // RL5
                s_next.ist[htd_pkg::IS_RESET] = 1'b1;
                if (s_reg.seq_bidir)
                    s_next.rst_ind = htd_pkg::RI_LONG_HW;            // RL11
                else if (s_reg.src == htd_pkg::SRC_HW)
                    s_next.rst_ind = (s_reg.low_cnt ==
                        htd_pkg::CNT_W'(htd_pkg::LONG_RST_CYC)) ?
                        htd_pkg::RI_LONG_HW : htd_pkg::RI_SHORT_HW;
                else if (s_reg.src == htd_pkg::SRC_WDT)
                    s_next.rst_ind = htd_pkg::RI_WDT;
                else
                    s_next.rst_ind = htd_pkg::RI_SW;
                if (s_reg.seq_bidir || s_reg.src == htd_pkg::SRC_HW)
                begin
                    s_next.boot_cfg  = startup_config_port;          // RL12
                    s_next.boot_mode =
                        !startup_config_port[htd_pkg::BOOT_BIT];
                end
            end
        end
        s_next.pin_out   = 1'b0;
        s_next.block_irq = s_next.lvl != htd_pkg::LVL_NONE;         // RL4
        s_next.irq       = |(s_next.ist & s_next.imask);
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            s_reg <= htd_pkg::ST_RESET;
        else
            s_reg <= s_next;
    end

    // Outputs straight from the state register
    assign avs_readdata        = s_reg.rdata;
    assign avs_waitrequest     = s_reg.wait_rq;
    assign vec_out             = s_reg.vec;
    assign block_irq           = s_reg.block_irq;
    assign reset_input_pin_out = s_reg.pin_out;
    assign reset_input_pin_oe  = s_reg.pin_oe;
    assign core_reset          = s_reg.core_rst;
    assign bootstrap_mode      = s_reg.boot_mode;
    assign irq                 = s_reg.irq;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    // Checks
    vec_addr_a: assert property ($rose(s_reg.vec.valid) |->  // RL15
        s_reg.vec.addr == {7'h00, s_reg.vec.num, 2'b00})
        else $error("vector address not four times number");
    flag_set_a: assert property (|hw_trap_evt |=>  // RL2
        (s_reg.tflag & $past(hw_trap_evt)) == $past(hw_trap_evt))
        else $error("trap flag not set");
    flag_keep_a: assert property (  // RL16
        !(wr && avs_address == htd_pkg::OFF_TRAP_FLAG) |=>
        (s_reg.tflag & $past(s_reg.tflag)) == $past(s_reg.tflag))
        else $error("trap flag lost without write");
    preempt_a: assert property (  // RL3
        s_reg.pend[2:0] != '0 && s_reg.lvl != htd_pkg::LVL_A &&
        !s_reg.vec.valid && !s_reg.seq_busy && !rst_start |=>
        s_reg.vec.valid && s_reg.lvl == htd_pkg::LVL_A)
        else $error("class A trap not dispatched");
    class_b_a: assert property (  // RL7
        $rose(s_reg.vec.valid) && s_reg.lvl == htd_pkg::LVL_B &&
        $past(s_reg.lvl) == htd_pkg::LVL_NONE |->
        s_reg.vec.num == htd_pkg::NUM_CLASS_B)
        else $error("class B trap wrong vector");
    node_block_a: assert property (s_reg.block_irq |->  // RL4
        node_take == '0)
        else $error("node taken during trap service");
    node_vec_a: assert property (node_take[0] |=>  // RL9
        s_reg.vec.valid && s_reg.vec.num == htd_pkg::NODE_NUM[0])
        else $error("node vector wrong");
    reset_vec_a: assert property ($fell(s_reg.core_rst) |->  // RL5
        s_reg.vec.valid && s_reg.vec.num == htd_pkg::NUM_RESET)
        else $error("reset did not vector to zero");
    bidir_clr_a: assert property ($rose(s_reg.seq_busy) |->  // RL10
        !s_reg.bidir_en ##1 !s_reg.bidir_en)
        else $error("bidir enable not cleared by reset");
    long_ind_a: assert property (  // RL11
        $fell(s_reg.seq_busy) && s_reg.seq_bidir |->
        s_reg.rst_ind == htd_pkg::RI_LONG_HW)
        else $error("bidir reset not reported long");
    cfg_latch_a: assert property (  // RL12
        $fell(s_reg.seq_busy) && s_reg.seq_bidir |->
        s_reg.boot_cfg == $past(startup_config_port))
        else $error("startup config not latched");
    stretch_a: assert property (s_reg.seq_busy && s_reg.seq_bidir |->  // RL13
        s_reg.pin_oe && s_reg.core_rst)
        else $error("bidir reset not stretched");
    class_a_c: cover property ($rose(s_reg.vec.valid) &&
        s_reg.lvl == htd_pkg::LVL_A);
    class_b_c: cover property ($rose(s_reg.vec.valid) &&
        s_reg.lvl == htd_pkg::LVL_B);
    bidir_end_c: cover property ($fell(s_reg.seq_busy) && s_reg.seq_bidir);
    node_c: cover property (|node_take);
endmodule

`default_nettype wire

// ---- pkg/htd_pkg.sv ----
`default_nettype none

package htd_pkg;

    // Clock and reset sequence timing
    localparam int CLK_MHZ      = 200;
    localparam int RST_SEQ_NS   = 2560;
    localparam int RST_SEQ_CYC  = (RST_SEQ_NS * CLK_MHZ + 999) / 1000;
    localparam int LONG_RST_NS  = 5120;
    localparam int LONG_RST_CYC = (LONG_RST_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W        = 12;

    // Event counts
    localparam int HW_COUNT   = 8;
    localparam int A_COUNT    = 3;
    localparam int NODE_COUNT = 4;
    localparam int IRQ_W      = 4;

    // Register byte offsets
    localparam logic [7:0] OFF_TRAP_FLAG = 8'h00;
    localparam logic [7:0] OFF_SYS_CFG   = 8'h04;
    localparam logic [7:0] OFF_RST_IND   = 8'h08;
    localparam logic [7:0] OFF_BOOT_CFG  = 8'h0C;
    localparam logic [7:0] OFF_NODE_REQ  = 8'h10;
    localparam logic [7:0] OFF_NODE_EN   = 8'h14;
    localparam logic [7:0] OFF_IRQ_STAT  = 8'h18;
    localparam logic [7:0] OFF_IRQ_MASK  = 8'h1C;

    // Field positions
    localparam int SC_BIDIR   = 0;
    localparam int SC_END_OF_INIT_INSTRUCTION   = 1;
    localparam int TF_NMI     = 0;
    localparam int TF_STK_OVR = 1;
    localparam int TF_STK_UND = 2;
    localparam int TF_UNDEF   = 3;
    localparam int TF_PROT    = 4;
    localparam int TF_OPERAND = 5;
    localparam int TF_INSTR   = 6;
    localparam int TF_BUS     = 7;
    localparam int IS_CLASS_A = 0;
    localparam int IS_CLASS_B = 1;
    localparam int IS_SW      = 2;
    localparam int IS_RESET   = 3;
    localparam int BOOT_BIT   = 4;

    // Trap numbers
    localparam logic [6:0] NUM_RESET   = 7'h00;
    localparam logic [6:0] NUM_NMI     = 7'h02;
    localparam logic [6:0] NUM_STK_OVR = 7'h04;
    localparam logic [6:0] NUM_STK_UND = 7'h06;
    localparam logic [6:0] NUM_CLASS_B = 7'h0A;
    localparam logic [A_COUNT-1:0][6:0] A_NUM =
        {NUM_STK_UND, NUM_STK_OVR, NUM_NMI};
    localparam logic [NODE_COUNT-1:0][6:0] NODE_NUM =
        {7'h47, 7'h1B, 7'h1A, 7'h19};

    // Reset indication codes
    localparam logic [1:0] RI_WDT      = 2'h0;
    localparam logic [1:0] RI_SW       = 2'h1;
    localparam logic [1:0] RI_SHORT_HW = 2'h2;
    localparam logic [1:0] RI_LONG_HW  = 2'h3;

    typedef enum logic [1:0] {LVL_NONE, LVL_B, LVL_A} htd_lvl_t;
    typedef enum logic [1:0] {SRC_HW, SRC_SW, SRC_WDT} htd_src_t;

    typedef struct packed {
        logic        req;
        logic        en;
    } htd_node_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] addr;
        logic [6:0]  num;
    } htd_vec_t;

    typedef struct packed {
        logic                wait_rq;
        logic [31:0]         rdata;
        logic [HW_COUNT-1:0] tflag;
        logic [HW_COUNT-1:0] pend;
        logic                sw_pend;
        logic [6:0]          sw_num;
        htd_lvl_t            lvl;
        htd_lvl_t            prev_lvl;
        htd_vec_t            vec;
        logic                block_irq;
        logic                bidir_en;
        logic                end_of_init_instruction_done;
        logic                seq_bidir;
        htd_src_t            src;
        logic [1:0]          rst_ind;
        logic [15:0]         boot_cfg;
        logic                boot_mode;
        logic                seq_busy;
        logic                core_rst;
        logic [CNT_W-1:0]    seq_cnt;
        logic [CNT_W-1:0]    low_cnt;
        logic                pin_oe;
        logic                pin_out;
        logic [IRQ_W-1:0]    ist;
        logic [IRQ_W-1:0]    imask;
        logic                irq;
    } htd_state_t;

    localparam htd_state_t ST_RESET = '{wait_rq: 1'b1, lvl: LVL_NONE,
        prev_lvl: LVL_NONE, src: SRC_HW, default: '0};

    // Vector entries are four bytes each
    function automatic htd_vec_t vec_of(input logic [6:0] num);
        return '{valid: 1'b1, addr: {7'h00, num, 2'b00}, num: num}; // RL15
    endfunction

endpackage

`default_nettype wire

// ---- hw/htd_node.sv ----
`default_nettype none

// One interrupt node: request flag plus enable flag
module htd_node (
    input  wire logic sys_clk,  // CPU clock
    input  wire logic reset_n,  // Async reset, active low
    input  wire logic set_evt,  // Source event pulse
    input  wire logic take,     // Node vector dispatched
    input  wire logic wr_req,   // Software writes request
    input  wire logic wr_en,    // Software writes enable
    input  wire logic req_d,    // Written request value
    input  wire logic en_d,     // Written enable value
    output logic      req,      // Request flag
    output logic      en        // Enable flag
);
    htd_pkg::htd_node_t s_reg;
    htd_pkg::htd_node_t s_next;

    // Source event applied last so it beats any clear
    always_comb
    begin
        s_next = s_reg;
        if (wr_req)
            s_next.req = req_d;
        if (take)
            s_next.req = 1'b0;
        if (wr_en)
            s_next.en = en_d;
        if (set_evt)
            s_next.req = 1'b1;
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end

    assign req = s_reg.req;
    assign en  = s_reg.en;
endmodule

`default_nettype wire

// ---- verification/htd_core_model.sv ----
`default_nettype none

// Pipeline side: accepts each offered vector, promptly or late
module htd_core_model (
    input  wire logic              sys_clk,  // CPU clock
    input  wire logic              reset_n,  // Async reset, active low
    input  wire logic              slow,     // Late accept when high
    input  wire htd_pkg::htd_vec_t vec_out,  // Offered vector
    output logic                   vec_take  // Vector accepted
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [1:0] dly_reg;

    // One-cycle accept; the late path waits so held vectors get exercised
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            vec_take <= 1'b0;
            dly_reg  <= 2'h0;
        end
        else if (vec_out.valid && !vec_take)
        begin
            dly_reg  <= dly_reg + 2'h1;
            vec_take <= !slow || dly_reg == 2'h2;
        end
        else
        begin
            vec_take <= 1'b0;
            dly_reg  <= 2'h0;
        end
    end
endmodule

`default_nettype wire

// ---- verification/htd_top_tb_top.sv ----
`default_nettype none

module htd_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic              sys_clk = 0, reset_n = 0, slow = 0, ext_pin = 1;
    logic [7:0]        avs_address = 8'h00, hw_trap_evt = 8'h00;
    logic              avs_read = 0, avs_write = 0, avs_waitrequest;
    logic [31:0]       avs_writedata = 32'h0, avs_readdata, q;
    logic              sw_trap_req = 0, trap_return = 0, vec_take;
    logic [6:0]        sw_trap_num = 7'h00;
    logic [3:0]        node_evt = 4'h0;
    logic              sw_reset_req = 0, wdt_overflow = 0, block_irq, pin_out;
    logic              end_of_init_instruction = 0, pin_lvl, irq;
    logic              reset_input_pin_oe, core_reset, bootstrap_mode;
    logic [15:0]       startup_config_port = 16'hFFFF;
    htd_pkg::htd_vec_t vec_out;
    int                error_cnt = 0, cmp_count = 0, cyc = 0;
    // Hardware rows: source kind, index, expected trap number
    localparam logic [10:0] ROWS [11] = '{{4'h0, 7'h02}, {4'h1, 7'h04},
        {4'h2, 7'h06}, {4'h3, 7'h0A}, {4'h4, 7'h0A}, {4'h5, 7'h0A},
        {4'h6, 7'h0A}, {4'h7, 7'h0A}, {4'h8, 7'h19}, {4'h9, 7'h1A},
        {4'hB, 7'h47}};

    // Open-drain pin with pull-up; external side pulls low only for the short pin reset
    assign pin_lvl = reset_input_pin_oe ? 1'b0 : ext_pin;

    htd_top i_dut (.sys_clk, .reset_n, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
        .hw_trap_evt, .sw_trap_req, .sw_trap_num, .trap_return, .node_evt,
        .vec_take, .vec_out, .block_irq, .sw_reset_req, .wdt_overflow,
        .end_of_init_instruction, .reset_input_pin_in(pin_lvl),
        .reset_input_pin_out(pin_out), .reset_input_pin_oe,
        .startup_config_port,
        .core_reset, .bootstrap_mode, .irq);
    htd_core_model i_core (.sys_clk, .reset_n, .slow, .vec_out, .vec_take);

    // 200 MHz clock
    always #2.5 sys_clk = ~sys_clk;

    // Hang guard, well above the three reset sequences
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        if (error_cnt == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Request held until waitrequest is sampled low; an idle edge follows
    task automatic bus(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        avs_address   <= a;
        avs_writedata <= d;
        avs_read      <= !wr;
        avs_write     <= wr;
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0)
            @(posedge sys_clk);
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(q, exp);
    endtask

    // Waits for an accepted vector; address is four times the number
    task automatic wv(input logic [6:0] num);
        @(posedge sys_clk);
        while (!(vec_out.valid === 1'b1 && vec_take === 1'b1))
            @(posedge sys_clk);
        chk({vec_out.addr, 9'h0, vec_out.num}, {7'h0, num, 2'h0, 9'h0, num});
    endtask

    task automatic ret();
        trap_return <= 1'b1;
        @(posedge sys_clk);
        trap_return <= 1'b0;
        @(posedge sys_clk);
    endtask

    // Main sequence
    initial
    begin
        repeat (10) @(posedge sys_clk);
        reset_n <= 1'b1;
        rdc(htd_pkg::OFF_SYS_CFG, 32'h0);
        bus(1'b1, htd_pkg::OFF_NODE_EN, 32'hF);
        for (int i = 0; i < 11; i++)
        begin
            slow <= i[0];
            if (ROWS[i][10])
                node_evt <= 4'h1 << ROWS[i][8:7];
            else
                hw_trap_evt <= 8'h01 << ROWS[i][9:7];
            @(posedge sys_clk);
            node_evt    <= 4'h0;
            hw_trap_evt <= 8'h00;
            wv(ROWS[i][6:0]);
            if (!ROWS[i][10])
            begin
                chk({31'h0, block_irq}, 32'h1);
                ret();
            end
        end
        rdc(htd_pkg::OFF_TRAP_FLAG, 32'hFF);
        bus(1'b1, htd_pkg::OFF_TRAP_FLAG, 32'hFF);
        rdc(htd_pkg::OFF_TRAP_FLAG, 32'h0);
        hw_trap_evt <= 8'h08;
        @(posedge sys_clk);
        hw_trap_evt <= 8'h01;
        @(posedge sys_clk);
        hw_trap_evt <= 8'h00;
        wv(7'h0A);
        wv(7'h02);
        ret();
        ret();
        sw_trap_req <= 1'b1;
        sw_trap_num <= 7'h7F;
        @(posedge sys_clk);
        sw_trap_req <= 1'b0;
        wv(7'h7F);
        bus(1'b1, htd_pkg::OFF_IRQ_MASK, 32'h2);
        repeat (2) @(posedge sys_clk);
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, htd_pkg::OFF_IRQ_STAT, 32'hF);
        repeat (2) @(posedge sys_clk);
        chk({31'h0, irq}, 32'h0);
        rdc(8'h20, 32'h0);
        sw_reset_req <= 1'b1;
        @(posedge sys_clk);
        sw_reset_req <= 1'b0;
        wv(7'h00);
        rdc(htd_pkg::OFF_TRAP_FLAG, 32'h09);
        rdc(htd_pkg::OFF_RST_IND, {30'h0, htd_pkg::RI_SW});
        bus(1'b1, htd_pkg::OFF_SYS_CFG, 32'h1);
        end_of_init_instruction <= 1'b1;
        @(posedge sys_clk);
        end_of_init_instruction <= 1'b0;
        bus(1'b1, htd_pkg::OFF_SYS_CFG, 32'h0);
        rdc(htd_pkg::OFF_SYS_CFG, 32'h3);
        startup_config_port <= 16'hFFEF;
        wdt_overflow <= 1'b1;
        @(posedge sys_clk);
        wdt_overflow <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk({29'h0, pin_out, reset_input_pin_oe, core_reset}, 32'h3);
        wv(7'h00);
        rdc(htd_pkg::OFF_RST_IND, {30'h0, htd_pkg::RI_LONG_HW});
        chk({31'h0, bootstrap_mode}, 32'h1);
        // Short pin reset outside bidir mode is reported short
        ext_pin <= 1'b0;
        repeat (3) @(posedge sys_clk);
        ext_pin <= 1'b1;
        wv(7'h00);
        rdc(htd_pkg::OFF_RST_IND, {30'h0, htd_pkg::RI_SHORT_HW});
        print_verdict();
    end
endmodule

`default_nettype wire
